// File: jtag_isp_defs.svh
// constants for the serial in-system configuration port
`ifndef JTAG_ISP_DEFS_SVH
`define JTAG_ISP_DEFS_SVH

// clock and flash cycle timing
`define CLK_PERIOD_NS 5
`define PROG_TIME_NS 80
`define ERASE_TIME_NS 320
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYCLES ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 8

// register byte offsets
`define REG_EVENTS 12'h000
`define REG_MASK 12'h004
`define REG_STATE 12'h008

// event bit positions
`define EV_ENABLED 0
`define EV_DONE 1
`define EV_ERROR 2
`define EV_DISABLED 3
`define EV_BLOCKED 4
`define EV_W 5
`define MASK_RESET 5'h00

// instruction register
`define IR_W 8
`define IR_CAPTURE 8'h01
`define IR_BYPASS 8'hFF
`define IR_READ 8'h0A
`define IR_PROGRAM 8'h0B
`define IR_ENABLE 8'h0C
`define IR_CHIP_ERASE 8'h0D
`define IR_ERASE 8'h0E
`define IR_DISABLE 8'h0F
`define IR_CLEAR 8'h10
`define IR_STATUS 8'h11
`define IR_CONFIG 8'h12

// data register layout
`define DR_W 32
`define ENA_EXT_BIT 0
`define ENA_OD_BIT 1
`define BLANK_BYTE 8'hFF

`endif

// File: jtag_isp_pkg.sv
// types shared by the configuration port
package jtag_isp_pkg;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;
  typedef enum logic [1:0] {FL_READ, FL_PROG, FL_ERASE, FL_CHIP} flash_state_t;
endpackage

// File: jtag_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module jtag_pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,               // sampling clock
  input wire logic rst_n,             // async reset, active low
  input wire logic [WIDTH-1:0] pin_in, // raw pins
  output logic [WIDTH-1:0] level      // filtered level
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  // per bit: chain of three, level moves once stages two and three agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        s1[i] <= RST_VAL[i];
        s2[i] <= RST_VAL[i];
        s3[i] <= RST_VAL[i];
        level[i] <= RST_VAL[i];
      end else begin
        s1[i] <= pin_in[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: jtag_isp_config_port.sv
// serial in-system configuration port with flash model and apb status
`timescale 1ns/10ps
`default_nettype none
`include "jtag_isp_defs.svh"
// Behaviour
// - test pins inputs, data out undriven
// - enable command turns data out driven
// - enable option activates status and error pins
// - enable option selects open-drain extension pins
// - boundary-scan instructions act as bypass only
// - error pin low on erase/program failure
// - error holds until clear or reset-after-disable
// - status high while flash in read
// - status low while program or erase runs
// - blank device pins are test signals
// - program flash arrays, logic, configuration bits
// - security lock refuses every content read
// - locked port accepts only full-chip erase
// - full-chip erase clears lock, leaves blank
// - protected sector refuses erase
// - factory state reads all ones
// - chip reset aborts cycle to read
module jtag_isp_config_port import jtag_isp_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int SECT_W = 3,
  parameter int PAW = 12
) (
  input wire logic pclk,              // system clock
  input wire logic presetn,           // async reset, active low
  input wire logic [PAW-1:0] paddr,   // apb address
  input wire logic psel,              // apb select
  input wire logic penable,           // apb enable
  input wire logic pwrite,            // apb direction
  input wire logic [31:0] pwdata,     // apb write data
  output logic [31:0] prdata,         // apb read data
  output logic pready,                // apb ready
  output logic pslverr,               // apb error
  input wire logic tck,               // test clock pin
  input wire logic tms,               // test mode select pin
  input wire logic tdi,               // test data in pin
  input wire logic chip_reset_n,      // chip reset pin, active low
  output logic tdo,                   // test data out
  output logic tdo_oe,                // test data out enable
  output logic flash_status_out,      // flash ready status
  output logic flash_status_oe,       // status pin enable
  output logic flash_error_out_n,     // flash error, active low
  output logic flash_error_oe,        // error pin enable
  output logic irq                    // level interrupt
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int NSECT = 1 << SECT_W;
  // every check below runs on the system clock
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [3:0] pin_lvl;
  logic tck_q, crst_q;
  tap_state_t tap_state, next_tap;
  logic [`IR_W-1:0] ir, ir_shift;
  logic [`DR_W-1:0] dr_shift;
  logic enabled, ext_en, od_en, disable_seen, flash_err, secure;
  logic [NSECT-1:0] protect;
  flash_state_t fstate;
  logic [`CNT_W-1:0] fcount;
  logic [ADDR_W-1:0] op_addr, read_addr;
  logic [7:0] op_data;
  logic [SECT_W-1:0] op_sect;
  logic op_cfg;
  logic [NSECT:0] op_cfg_bits;
  logic [7:0] mem [0:DEPTH-1];
  logic [`EV_W-1:0] events, mask;

  // dedicated test pins sampled from reset onward
  jtag_pin_sync #(.WIDTH(4), .RST_VAL(4'h8)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .pin_in({chip_reset_n, tck, tms, tdi}),
    .level(pin_lvl)
  );

  // edges of the filtered pins
  wire tck_s = pin_lvl[2];
  wire tms_s = pin_lvl[1];
  wire tdi_s = pin_lvl[0];
  wire tck_rise = tck_s & ~tck_q;
  wire tck_fall = ~tck_s & tck_q;
  wire chip_rst_fall = ~pin_lvl[3] & crst_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_q <= 1'b0;
      crst_q <= 1'b1;
    end else begin
      tck_q <= tck_s;
      crst_q <= pin_lvl[3];
    end
  end

  always_comb begin
    next_tap = tap_state;
    unique case (tap_state)
      TAP_RESET: next_tap = tms_s ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_tap = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_tap = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: next_tap = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: next_tap = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: next_tap = tms_s ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_tap = tms_s ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_tap = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: next_tap = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: next_tap = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: next_tap = tms_s ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: next_tap = tms_s ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  // command decode at update-dr; unknown codes behave as bypass
  wire upd = tck_rise && (tap_state == TAP_UPD_DR);
  wire idle = (fstate == FL_READ);
  wire cmd_enable = upd && (ir == `IR_ENABLE);
  wire cmd_disable = upd && enabled && (ir == `IR_DISABLE);
  wire cmd_clear = upd && enabled && (ir == `IR_CLEAR);
  wire cmd_prog = upd && enabled && (ir == `IR_PROGRAM);
  wire cmd_cfg = upd && enabled && (ir == `IR_CONFIG);
  wire cmd_erase = upd && enabled && (ir == `IR_ERASE);
  wire cmd_chip = upd && enabled && (ir == `IR_CHIP_ERASE);
  wire cmd_read = upd && enabled && (ir == `IR_READ);
  wire is_bypass = !((ir == `IR_READ) || (ir == `IR_STATUS) ||
                     (ir == `IR_ENABLE) || (ir == `IR_PROGRAM) ||
                     (ir == `IR_CONFIG) || (ir == `IR_ERASE) ||
                     (ir == `IR_CHIP_ERASE) || (ir == `IR_DISABLE) ||
                     (ir == `IR_CLEAR));
  wire [SECT_W-1:0] dr_sect = dr_shift[SECT_W-1:0];
  // locked port takes only the full-chip erase
  wire lock_block = secure && (cmd_prog || cmd_cfg || cmd_erase || cmd_read);
  wire busy_block = !idle && (cmd_prog || cmd_cfg || cmd_erase || cmd_chip);
  wire start_prog = (cmd_prog || cmd_cfg) && idle && !secure;
  wire erase_refused = cmd_erase && idle && !secure && protect[dr_sect];
  wire start_erase = cmd_erase && idle && !secure && !protect[dr_sect];
  wire start_chip = cmd_chip && idle;
  wire abort = chip_rst_fall && !idle;
  wire op_end = !idle && (fcount == '0) && !abort;
  wire wr_byte = op_end && (fstate == FL_PROG) && !op_cfg;
  wire wipe_sect = op_end && (fstate == FL_ERASE);
  wire wipe_all = op_end && (fstate == FL_CHIP);
  wire prog_fail = wr_byte && ((mem[op_addr] & op_data) != op_data);
  wire err_set = prog_fail || erase_refused;
  wire err_clr = cmd_clear || (chip_rst_fall && disable_seen);
  // secured or busy flash returns zeros on read
  wire [7:0] read_byte = (secure || !idle) ? 8'h00 : mem[read_addr];
  wire [7:0] state_byte = {3'h0, secure, flash_err, !idle, od_en, ext_en};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_state <= TAP_RESET;
      ir <= `IR_BYPASS;
      ir_shift <= `IR_BYPASS;
    end else if (tck_rise) begin
      tap_state <= next_tap;
      if (tap_state == TAP_RESET) ir <= `IR_BYPASS;
      if (tap_state == TAP_CAP_IR) ir_shift <= `IR_CAPTURE;
      if (tap_state == TAP_SHIFT_IR) ir_shift <= {tdi_s, ir_shift[`IR_W-1:1]};
      if (tap_state == TAP_UPD_IR) ir <= ir_shift;
    end
  end

  // data register; bypass uses only the lowest bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dr_shift <= '0;
    end else if (tck_rise && tap_state == TAP_CAP_DR) begin
      if (ir == `IR_READ) dr_shift <= {24'h000000, read_byte};
      else if (ir == `IR_STATUS) dr_shift <= {24'h000000, state_byte};
      else dr_shift <= '0;
    end else if (tck_rise && tap_state == TAP_SHIFT_DR) begin
      if (is_bypass) dr_shift[0] <= tdi_s;
      else dr_shift <= {tdi_s, dr_shift[`DR_W-1:1]};
    end
  end

  // port configuration and error flag; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enabled <= 1'b0;
      ext_en <= 1'b0;
      od_en <= 1'b0;
      disable_seen <= 1'b0;
      flash_err <= 1'b0;
      read_addr <= '0;
    end else begin
      if (cmd_enable) begin
        enabled <= 1'b1;
        // extension pin options from the command
        ext_en <= dr_shift[`ENA_EXT_BIT];
        od_en <= dr_shift[`ENA_OD_BIT];
        disable_seen <= 1'b0;
      end else if (cmd_disable) begin
        enabled <= 1'b0;
        disable_seen <= 1'b1;
      end else if (chip_rst_fall && disable_seen) begin
        ext_en <= 1'b0;
        disable_seen <= 1'b0;
      end
      if (err_set) flash_err <= 1'b1;
      else if (err_clr) flash_err <= 1'b0;
      if (cmd_read) read_addr <= dr_shift[ADDR_W+7:8];
    end
  end

  // flash engine: program, config, sector and chip erase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fstate <= FL_READ;
      fcount <= '0;
      op_addr <= '0;
      op_data <= `BLANK_BYTE;
      op_sect <= '0;
      op_cfg <= 1'b0;
      op_cfg_bits <= '0;
      secure <= 1'b0;
      protect <= '0;
    end else if (abort) begin
      // chip reset aborts back to read
      fstate <= FL_READ;
    end else if (idle) begin
      if (start_prog) begin
        fstate <= FL_PROG;
        fcount <= `CNT_W'(`PROG_CYCLES - 1);
        op_addr <= dr_shift[ADDR_W+7:8];
        op_data <= dr_shift[7:0];
        op_cfg <= cmd_cfg;
        op_cfg_bits <= dr_shift[NSECT:0];
      end else if (start_erase) begin
        fstate <= FL_ERASE;
        fcount <= `CNT_W'(`ERASE_CYCLES - 1);
        op_sect <= dr_sect;
      end else if (start_chip) begin
        fstate <= FL_CHIP;
        fcount <= `CNT_W'(`ERASE_CYCLES - 1);
      end
    end else if (fcount != '0) begin
      fcount <= fcount - `CNT_W'(1);
    end else begin
      fstate <= FL_READ;
      if (fstate == FL_PROG && op_cfg) begin
        protect <= protect | op_cfg_bits[NSECT-1:0];
        secure <= secure | op_cfg_bits[NSECT];
      end
      // chip erase leaves an unsecured blank part
      if (fstate == FL_CHIP) begin
        secure <= 1'b0;
        protect <= '0;
      end
    end
  end

  // array entries start blank; program only clears bits
  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    wire [ADDR_W-1:0] ent_addr = ADDR_W'(i);
    wire [SECT_W-1:0] ent_sect = ent_addr[ADDR_W-1:ADDR_W-SECT_W];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) mem[i] <= `BLANK_BYTE;
      else if (wipe_all || (wipe_sect && ent_sect == op_sect))
        mem[i] <= `BLANK_BYTE;
      else if (wr_byte && op_addr == ADDR_W'(i)) mem[i] <= mem[i] & op_data;
    end
  end
  // pin drive values
  wire ready = idle;
  wire next_status_out = od_en ? 1'b0 : ready;
  wire next_status_oe = ext_en && (od_en ? !ready : 1'b1);
  wire next_err_out_n = od_en ? 1'b0 : !flash_err;
  wire next_err_oe = ext_en && (od_en ? flash_err : 1'b1);
  wire next_tdo = (tap_state == TAP_SHIFT_IR) ? ir_shift[0] : dr_shift[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      flash_status_out <= 1'b0;
      flash_status_oe <= 1'b0;
      flash_error_out_n <= 1'b0;
      flash_error_oe <= 1'b0;
    end else begin
      // data out driven only while enabled
      tdo_oe <= enabled;
      if (tck_fall) tdo <= next_tdo;
      flash_status_out <= next_status_out;
      flash_status_oe <= next_status_oe;
      flash_error_out_n <= next_err_out_n;
      flash_error_oe <= next_err_oe;
    end
  end

  // apb decode and event vector
  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire hit_ev = (paddr == `REG_EVENTS);
  wire hit_mask = (paddr == `REG_MASK);
  wire hit_state = (paddr == `REG_STATE);
  wire mapped = hit_ev || hit_mask || hit_state;
  wire [31:0] rd_mux = hit_ev ? {27'h0, events} :
                       hit_mask ? {27'h0, mask} :
                       hit_state ? {24'h0, state_byte} : 32'h00000000;
  wire [`EV_W-1:0] ev_set = {lock_block || busy_block, cmd_disable, err_set,
                             op_end, cmd_enable};
  wire [`EV_W-1:0] ev_clr = (access && !pwrite && hit_ev) ?
                            prdata[`EV_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      events <= '0;
      mask <= `MASK_RESET;
      irq <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup) prdata <= pwrite ? 32'h00000000 : rd_mux;
      events <= (events & ~ev_clr) | ev_set;
      if (access && pwrite && hit_mask) mask <= pwdata[`EV_W-1:0];
      irq <= |(events & mask);
    end
  end

  // checks
  property p_tdo_off;
    !enabled ##1 !enabled |-> !tdo_oe;
  endproperty
  a_tdo_off: assert property (p_tdo_off) else $error("tdo driven early");
  property p_tdo_on;
    cmd_enable |-> ##2 tdo_oe;
  endproperty
  a_tdo_on: assert property (p_tdo_on) else $error("tdo not driven");
  property p_ext_off;
    !ext_en ##1 !ext_en |-> !flash_status_oe && !flash_error_oe;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("ext pins active");
  property p_open_drain;
    (ext_en && od_en) ##1 (ext_en && od_en) |->
      !flash_status_out && !flash_error_out_n;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("od drives 1");
  property p_err_low;
    (prog_fail && ext_en && !od_en) ##1 (ext_en && !od_en) |=>
      !flash_error_out_n;
  endproperty
  a_err_low: assert property (p_err_low) else $error("error not low");
  property p_err_hold;
    flash_err && !err_clr |=> flash_err;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error dropped");
  property p_busy_low;
    (!idle && ext_en && !od_en) ##1 (ext_en && !od_en) |-> !flash_status_out;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("status high");
  property p_lock;
    (secure && idle && (cmd_prog || cmd_erase || cmd_cfg)) |=> idle;
  endproperty
  a_lock: assert property (p_lock) else $error("locked op ran");
  property p_unlock;
    wipe_all |=> !secure && protect == '0;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock kept");
  property p_protect;
    erase_refused |=> idle ##1 flash_err;
  endproperty
  a_protect: assert property (p_protect) else $error("erase ran");
  property p_abort;
    abort |=> idle;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  c_enable: cover property (cmd_enable ##[1:400] start_prog);
  c_program: cover property (wr_byte && !prog_fail);
  c_chip: cover property (wipe_all);
  c_refuse: cover property (erase_refused);
endmodule
`default_nettype wire

// File: jtag_isp_host_model.sv
// programming controller model that drives the test pins
`timescale 1ns/10ps
`default_nettype none
module jtag_isp_host_model (
  output logic tck,          // test clock, still between frames
  output logic tms,          // test mode select
  output logic tdi,          // test data in
  output logic chip_reset_n, // chip reset, active low
  input wire logic tdo,      // data out from the port
  input wire logic tdo_oe    // data out enable
);
  logic last_tdo;
  logic tdo_line;

  // an undriven data line shows the inverse of its last driven value
  assign tdo_line = (tdo_oe === 1'b1) ? tdo : ~last_tdo;

  // remember the last driven level
  always @* begin
    if (tdo_oe === 1'b1) last_tdo = tdo;
  end

  // pins idle with the clock standing low
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    chip_reset_n = 1'b1;
    last_tdo = 1'b0;
  end

  // one 48 ns clock period, data out taken late in the high phase
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #24 tck = 1'b1;
    #20 q = tdo_line;
    #4 tck = 1'b0;
  endtask

  task automatic tap_reset();
    logic q;
    repeat (5) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask

  task automatic scan(input logic ir_sel, input int n, input logic [31:0] d,
                      output logic [31:0] cap);
    logic q;
    cap = '0;
    tick(1'b1, 1'b0, q);
    if (ir_sel) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, d[i], q);
      cap[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask

  task automatic set_reset(input logic v);
    chip_reset_n <= v;
  endtask
endmodule
`default_nettype wire

// File: jtag_isp_config_port_tb_top.sv
// self-checking bench for the serial configuration port
`timescale 1ns/10ps
`default_nettype none
`include "jtag_isp_defs.svh"
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin fail_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, x); end end
module jtag_isp_config_port_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cap, seed;
  logic tck, tms, tdi, chip_reset_n, tdo, tdo_oe, irq;
  logic flash_status_out, flash_status_oe, flash_error_out_n, flash_error_oe;
  logic [7:0] d;
  logic [7:0] ad_q [4];
  logic [7:0] dt_q [4];
  int fail_count, n_checks, low_cnt, cyc, n;

  jtag_isp_config_port dut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .tck, .tms, .tdi,
    .chip_reset_n, .tdo, .tdo_oe, .flash_status_out, .flash_status_oe,
    .flash_error_out_n, .flash_error_oe, .irq);
  jtag_isp_host_model host (.tck, .tms, .tdi, .chip_reset_n, .tdo, .tdo_oe);

  // system clock, 5 ns period
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // busy time on the status pin and the run limit
  always @(posedge pclk) begin
    cyc++;
    if (flash_status_oe === 1'b1 && flash_status_out === 1'b0) low_cnt++;
    if (cyc == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic prog_err(input logic [7:0] old, input logic [7:0] nw);
    return |(nw & ~old);
  endfunction
  function automatic logic [7:0] prog_val(input logic [7:0] old,
                                          input logic [7:0] nw);
    return old & nw;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one apb transfer, waiting for pready
  task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= ad;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // load an instruction, then shift its data word
  task automatic cmd(input logic [7:0] ir, input logic [31:0] dr);
    logic [31:0] c;
    host.scan(1'b1, 8, {24'h0, ir}, c);
    if (tdo_oe === 1'b1) `CHK(c[7:0], 8'h01)
    host.scan(1'b0, 32, dr, cap);
    // the update edge needs a few system clocks through the pin filter
    repeat (8) @(posedge pclk);
  endtask

  task automatic wait_ready();
    for (n = 0; n < 400 && flash_status_out !== 1'b1; n++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    `CHK(flash_status_out, 1'b1)
  endtask

  task automatic op(input logic [7:0] ir, input logic [31:0] dr);
    low_cnt = 0;
    cmd(ir, dr);
    wait_ready();
  endtask

  // address load, then the next capture returns the byte
  task automatic rdbyte(input logic [7:0] ad, output logic [7:0] v);
    cmd(`IR_READ, {16'h0, ad, 8'h00});
    host.scan(1'b0, 32, 32'h0, cap);
    v = cap[7:0];
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    seed = 32'hEB2C707A;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    host.set_reset(1'b0);
    @(posedge pclk);
    `CHK({tdo_oe, flash_status_oe, flash_error_oe}, 3'b000)
    apb(`REG_MASK, 1'b0, 32'h0);
    `CHK(rd[4:0], `MASK_RESET)
    apb(12'h00C, 1'b0, 32'h0);
    `CHK({e, rd}, {1'b1, 32'h0})
    apb(`REG_MASK, 1'b1, 32'(1 << `EV_DONE));
    apb(`REG_MASK, 1'b0, 32'h0);
    `CHK({e, rd[4:0]}, {1'b0, 5'(1 << `EV_DONE)})
    host.tap_reset();
    cmd(`IR_PROGRAM, 32'h0000_2200);
    `CHK(tdo_oe, 1'b0)
    cmd(`IR_ENABLE, 32'h0);
    `CHK({tdo_oe, flash_status_oe}, 2'b10)
    cmd(`IR_ENABLE, 32'h3);
    `CHK({flash_status_oe, flash_status_out, flash_error_oe}, 3'b000)
    cmd(`IR_ENABLE, 32'h1);
    `CHK({flash_status_oe, flash_status_out, flash_error_oe, flash_error_out_n}, 4'hF)
    cmd(`IR_STATUS, 32'h0);
    `CHK(cap[7:0], 8'h01)
    apb(`REG_EVENTS, 1'b0, 32'h0);
    `CHK({rd[`EV_ENABLED], irq}, 2'b10)
    apb(`REG_EVENTS, 1'b0, 32'h0);
    `CHK(rd[`EV_ENABLED], 1'b0)
    rdbyte(8'h22, d);
    `CHK(d, `BLANK_BYTE)
    // random bytes into the first four sectors
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      ad_q[i] = {i[2:0], seed[4:0]};
      dt_q[i] = seed[15:8];
      op(`IR_PROGRAM, {16'h0, ad_q[i], dt_q[i]});
      `CHK((low_cnt >= `PROG_CYCLES - 1) && (low_cnt <= `PROG_CYCLES + 1), 1'b1)
      rdbyte(ad_q[i], d);
      `CHK(d, prog_val(8'hFF, dt_q[i]))
    end
    `CHK(irq, 1'b1)
    apb(`REG_EVENTS, 1'b0, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK({rd[`EV_DONE], irq}, 2'b10)
    // failing program in sector five
    op(`IR_PROGRAM, 32'h0000_A000);
    op(`IR_PROGRAM, 32'h0000_A0FF);
    `CHK(flash_error_out_n, ~prog_err(8'h00, 8'hFF))
    rdbyte(8'hA0, d);
    `CHK({d, flash_error_out_n}, {prog_val(8'h00, 8'hFF), 1'b0})
    op(`IR_CLEAR, 32'h0);
    `CHK(flash_error_out_n, 1'b1)
    apb(`REG_EVENTS, 1'b0, 32'h0);
    `CHK(rd[`EV_ERROR], 1'b1)
    // protected sector refuses erase
    op(`IR_CONFIG, 32'h1);
    op(`IR_ERASE, 32'h0);
    `CHK(flash_error_out_n, 1'b0)
    rdbyte(ad_q[0], d);
    `CHK(d, dt_q[0])
    op(`IR_CLEAR, 32'h0);
    // chip reset aborts a running erase
    host.set_reset(1'b1);
    repeat (8) @(posedge pclk);
    low_cnt = 0;
    cmd(`IR_ERASE, 32'h1);
    host.set_reset(1'b0);
    wait_ready();
    `CHK((low_cnt > 0) && (low_cnt < `ERASE_CYCLES), 1'b1)
    // locked device
    op(`IR_CONFIG, 32'h100);
    apb(`REG_STATE, 1'b0, 32'h0);
    `CHK(rd[7:0], 8'h11)
    rdbyte(ad_q[2], d);
    `CHK(d, 8'h00)
    apb(`REG_EVENTS, 1'b0, 32'h0);
    op(`IR_PROGRAM, {16'h0, ad_q[3], 8'h00});
    apb(`REG_EVENTS, 1'b0, 32'h0);
    `CHK(rd[`EV_BLOCKED], 1'b1)
    op(`IR_CHIP_ERASE, 32'h0);
    `CHK((low_cnt >= `ERASE_CYCLES - 1) && (low_cnt <= `ERASE_CYCLES + 1), 1'b1)
    rdbyte(ad_q[2], d);
    `CHK(d, `BLANK_BYTE)
    // unknown code acts as a one-bit bypass
    host.scan(1'b1, 8, 32'h0, cap);
    seed = xs(seed);
    host.scan(1'b0, 32, seed, cap);
    `CHK(cap, {seed[30:0], 1'b0})
    // error released by chip reset after disable
    op(`IR_PROGRAM, 32'h0000_4000);
    op(`IR_PROGRAM, 32'h0000_40FF);
    `CHK(flash_error_out_n, 1'b0)
    cmd(`IR_DISABLE, 32'h0);
    `CHK({tdo_oe, flash_error_out_n}, 2'b00)
    host.set_reset(1'b1);
    repeat (8) @(posedge pclk);
    host.set_reset(1'b0);
    for (n = 0; n < 40 && flash_error_oe !== 1'b0; n++) @(posedge pclk);
    `CHK({flash_error_oe, flash_error_out_n}, 2'b01)
    tally_and_finish();
  end
endmodule
`default_nettype wire
